//--- rtl/canm_bus_if.sv
`timescale 1ns/1ps
interface canm_bus_if;
  logic bit_tick;
  logic rx_dominant;
  modport source (output bit_tick, output rx_dominant);
  modport sink (input bit_tick, input rx_dominant);
endinterface

//--- rtl/canm_mode_control.sv
// Summary of operation
// - Wake on bus traffic only when enabled
// - Sleep entered only when bus idle
// - Sleep acknowledge set on sleep entry
// - Sleep request set blocked by wake flag
// - Sleep ends by software or wake clear
// - Init request aborts traffic, drops sync
// - Init acknowledge set on init entry
// - Init entry resets control and flag registers, not wake enable or requests
// - Config registers writable only in init
// - Error counters untouched by init mode
// - Resync needs 11 recessive, bus-off 128 runs
// - Transmit recessive in stop or wait-stop
// - Transmit recessive at once on init request
// - Sleep request clear ignored until asleep
// - Init request clear ignored until in init
// - Option register layout and reset value
// - Bus synchronized status kept by controller
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
module canm_mode_control
  import canm_pkg::*;
(
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic CAN_RX,
  input wire logic BIT_TICK,
  input wire logic TX_BIT,
  input wire logic RX_ACTIVE,
  input wire logic RX_FRAME_DONE,
  input wire logic TX_BUFFERS_EMPTY,
  input wire logic BUS_OFF,
  input wire logic [3:0] ERR_STATE,
  input wire logic CPU_STOP,
  input wire logic CPU_WAIT,
  output logic CAN_TX,
  output logic INIT_MODE,
  output logic SLEEP_MODE,
  output logic BUS_SYNC,
  output logic ABORT_XFER,
  output logic TIMER_ENABLE,
  output logic WAKE_PENDING,
  output logic [7:0] OPTION_CTRL,
  output logic [7:0] BIT_TIMING_0,
  output logic [7:0] BIT_TIMING_1
);
  canm_bus_if bus ();
  canm_mode_t state_reg;
  canm_mode_t state_next;

  logic rx_frame_reg;
  logic stop_in_wait_reg;
  logic timer_reg;
  logic wake_enable_reg;
  logic sleep_request_reg;
  logic init_request_reg;
  logic init_ack_reg;
  logic sleep_ack_reg;
  logic sync_reg;
  logic [7:2] option_reg;
  logic [7:0] timing0_reg;
  logic [7:0] timing1_reg;
  logic wake_flag_reg;
  logic [7:0] rxien_reg;

  logic setup;
  logic wr_access;
  logic wr_mode;
  logic wr_option;
  logic wr_timing0;
  logic wr_timing1;
  logic wr_rxflag;
  logic wr_rxien;
  logic cfg_open;
  logic init_entry;
  logic wake_pulse;
  logic run_done;
  logic busoff_done;
  logic sync_done;
  logic tx_force;
  logic addr_ok;
  logic [7:0] rd_byte;

  assign bus.bit_tick = BIT_TICK;
  assign bus.rx_dominant = ~CAN_RX;

  // APB: setup cycle prepares answer, first access cycle completes
  assign setup = PSEL && !PENABLE;
  assign wr_access = PSEL && PENABLE && PWRITE && PREADY;
  assign wr_mode = wr_access && (PADDR == ADDR_MODE);
  assign wr_option = wr_access && (PADDR == ADDR_OPTION);
  assign wr_timing0 = wr_access && (PADDR == ADDR_TIMING0);
  assign wr_timing1 = wr_access && (PADDR == ADDR_TIMING1);
  assign wr_rxflag = wr_access && (PADDR == ADDR_RXFLAG);
  assign wr_rxien = wr_access && (PADDR == ADDR_RXIEN);
  assign cfg_open = init_request_reg && init_ack_reg;
  assign init_entry = (state_reg != CANM_INIT) && (state_next == CANM_INIT);

  always_comb begin
    addr_ok = 1'b1;
    case (PADDR)
      ADDR_MODE: rd_byte = {rx_frame_reg, RX_ACTIVE, stop_in_wait_reg, sync_reg,
                            timer_reg && !init_ack_reg, wake_enable_reg,
                            sleep_request_reg, init_request_reg};
      ADDR_OPTION: rd_byte = {option_reg, sleep_ack_reg, init_ack_reg};
      ADDR_TIMING0: rd_byte = timing0_reg;
      ADDR_TIMING1: rd_byte = timing1_reg;
      ADDR_RXFLAG: rd_byte = {wake_flag_reg, 1'b0, ERR_STATE, 2'b00};
      ADDR_RXIEN: rd_byte = rxien_reg;
      default: begin
        rd_byte = 8'h00;
        addr_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0000_0000;
    end else begin
      PREADY <= setup;
      PSLVERR <= setup && !addr_ok;
      if (setup) begin
        PRDATA <= {24'h00_0000, rd_byte};
      end
    end
  end

  // Mode sequencing; init has priority over every other request
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      CANM_RUN: begin
        if (init_request_reg) begin
          state_next = CANM_INIT;
        end else if (sleep_request_reg && !RX_ACTIVE && TX_BUFFERS_EMPTY) begin
          state_next = CANM_SLEEP;
        end
      end
      CANM_SLEEP: begin
        if (init_request_reg) begin
          state_next = CANM_INIT;
        end else if (!sleep_request_reg) begin
          state_next = CANM_RUN;
        end
      end
      CANM_INIT: begin
        if (!init_request_reg) begin
          state_next = CANM_SYNC;
        end
      end
      CANM_SYNC: begin
        if (init_request_reg) begin
          state_next = CANM_INIT;
        end else if (sync_done) begin
          state_next = CANM_RUN;
        end
      end
      default: state_next = CANM_INIT;
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      state_reg <= CANM_INIT;
    end else begin
      state_reg <= state_next;
    end
  end

  // Handshake answers track the mode actually in force
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      init_ack_reg <= OPTION_RESET[OPT_INIT_ACK];
      sleep_ack_reg <= OPTION_RESET[OPT_SLEEP_ACK];
      sync_reg <= 1'b0;
    end else begin
      init_ack_reg <= (state_next == CANM_INIT);
      sleep_ack_reg <= (state_next == CANM_SLEEP);
      sync_reg <= (state_next == CANM_RUN);
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      init_request_reg <= MODE_RESET[MODE_INIT_REQ];
    end else if (wr_mode) begin
      if (PWDATA[MODE_INIT_REQ]) begin
        init_request_reg <= 1'b1;
      end else if (init_ack_reg) begin
        init_request_reg <= 1'b0;
      end
    end
  end

  // Bus wake clears the request even if software touched it this cycle
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      sleep_request_reg <= MODE_RESET[MODE_SLEEP_REQ];
    end else if (wake_pulse && wake_enable_reg) begin
      sleep_request_reg <= 1'b0;
    end else if (wr_mode) begin
      if (PWDATA[MODE_SLEEP_REQ] && !wake_flag_reg) begin
        sleep_request_reg <= 1'b1;
      end else if (!PWDATA[MODE_SLEEP_REQ] && sleep_ack_reg) begin
        sleep_request_reg <= 1'b0;
      end
    end
  end

  // Wake enable survives init entry; it governs the next sleep period
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      wake_enable_reg <= MODE_RESET[MODE_WAKE_EN];
    end else if (wr_mode) begin
      wake_enable_reg <= PWDATA[MODE_WAKE_EN];
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET || init_entry) begin
      stop_in_wait_reg <= MODE_RESET[MODE_STOP_IN_WAIT];
      timer_reg <= MODE_RESET[MODE_TIMER];
    end else if (wr_mode) begin
      stop_in_wait_reg <= PWDATA[MODE_STOP_IN_WAIT];
      timer_reg <= PWDATA[MODE_TIMER];
    end
  end

  // Frame flag: write one clears, a new frame in the same cycle wins
  always_ff @(posedge MCLK) begin
    if (RESET || init_entry) begin
      rx_frame_reg <= MODE_RESET[MODE_RX_FRAME];
    end else if (RX_FRAME_DONE) begin
      rx_frame_reg <= 1'b1;
    end else if (wr_mode && PWDATA[MODE_RX_FRAME]) begin
      rx_frame_reg <= 1'b0;
    end
  end

  // Error-state fields are live inputs and never reset here
  always_ff @(posedge MCLK) begin
    if (RESET || init_entry) begin
      wake_flag_reg <= RXFLAG_RESET[RXF_WAKE];
    end else if (wake_pulse && wake_enable_reg) begin
      wake_flag_reg <= 1'b1;
    end else if (wr_rxflag && PWDATA[RXF_WAKE]) begin
      wake_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET || init_entry) begin
      rxien_reg <= RXIEN_RESET;
    end else if (wr_rxien) begin
      rxien_reg <= PWDATA[7:0];
    end
  end

  // Configuration registers locked outside initialization
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      option_reg <= OPTION_RESET[7:2];
    end else if (wr_option && cfg_open) begin
      option_reg <= PWDATA[7:2];
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      timing0_reg <= TIMING_RESET;
      timing1_reg <= TIMING_RESET;
    end else begin
      if (wr_timing0 && cfg_open) begin
        timing0_reg <= PWDATA[7:0];
      end
      if (wr_timing1 && cfg_open) begin
        timing1_reg <= PWDATA[7:0];
      end
    end
  end

  // Resync: runs of recessive bits, chained for bus-off recovery
  canm_run_counter #(
    .COUNT(SYNC_RECESSIVE_BITS),
    .W(4)
  ) u_recessive_run (
    .clk(MCLK),
    .rst(RESET),
    .clear(state_reg != CANM_SYNC),
    .event_in(BIT_TICK && CAN_RX),
    .break_in(BIT_TICK && !CAN_RX),
    .done(run_done)
  );

  canm_run_counter #(
    .COUNT(BUSOFF_SEQUENCES),
    .W(8)
  ) u_busoff_runs (
    .clk(MCLK),
    .rst(RESET),
    .clear(state_reg != CANM_SYNC),
    .event_in(run_done),
    .break_in(1'b0),
    .done(busoff_done)
  );

  assign sync_done = BUS_OFF ? busoff_done : run_done;

  canm_wake_filter u_wake (
    .clk(MCLK),
    .rst(RESET),
    .armed((state_reg == CANM_SLEEP) && wake_enable_reg),
    .filter_on(option_reg[OPT_WAKE_FILTER]),
    .bus(bus.sink),
    .wake(wake_pulse)
  );

  // A pending init write already forces recessive in the same cycle
  assign tx_force = init_request_reg || (wr_mode && PWDATA[MODE_INIT_REQ])
    || CPU_STOP || (CPU_WAIT && stop_in_wait_reg)
    || (state_reg != CANM_RUN) || option_reg[OPT_LOOPBACK]
    || option_reg[OPT_MONITOR] || !option_reg[OPT_MODULE_EN];

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      CAN_TX <= 1'b1;
    end else begin
      CAN_TX <= tx_force ? 1'b1 : TX_BIT;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      ABORT_XFER <= 1'b0;
      INIT_MODE <= 1'b1;
      SLEEP_MODE <= 1'b0;
      BUS_SYNC <= 1'b0;
      TIMER_ENABLE <= 1'b0;
      WAKE_PENDING <= 1'b0;
    end else begin
      ABORT_XFER <= init_entry;
      INIT_MODE <= (state_next == CANM_INIT);
      SLEEP_MODE <= (state_next == CANM_SLEEP);
      BUS_SYNC <= (state_next == CANM_RUN);
      TIMER_ENABLE <= timer_reg && !init_ack_reg;
      WAKE_PENDING <= wake_flag_reg && rxien_reg[RXIE_WAKE];
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      OPTION_CTRL <= OPTION_RESET;
      BIT_TIMING_0 <= TIMING_RESET;
      BIT_TIMING_1 <= TIMING_RESET;
    end else begin
      OPTION_CTRL <= {option_reg, sleep_ack_reg, init_ack_reg};
      BIT_TIMING_0 <= timing0_reg;
      BIT_TIMING_1 <= timing1_reg;
    end
  end
endmodule

//--- rtl/canm_pkg.sv
package canm_pkg;

  // Register indices; byte address is four times the index
  localparam int unsigned REG_IDX_MODE = 0;
  localparam int unsigned REG_IDX_OPTION = 1;
  localparam int unsigned REG_IDX_TIMING0 = 2;
  localparam int unsigned REG_IDX_TIMING1 = 3;
  localparam int unsigned REG_IDX_RXFLAG = 4;
  localparam int unsigned REG_IDX_RXIEN = 5;
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] ADDR_MODE = 8'(REG_IDX_MODE * 4);
  localparam logic [7:0] ADDR_OPTION = 8'(REG_IDX_OPTION * 4);
  localparam logic [7:0] ADDR_TIMING0 = 8'(REG_IDX_TIMING0 * 4);
  localparam logic [7:0] ADDR_TIMING1 = 8'(REG_IDX_TIMING1 * 4);
  localparam logic [7:0] ADDR_RXFLAG = 8'(REG_IDX_RXFLAG * 4);
  localparam logic [7:0] ADDR_RXIEN = 8'(REG_IDX_RXIEN * 4);

  // mode_request_control fields
  localparam int unsigned MODE_RX_FRAME = 7;
  localparam int unsigned MODE_RX_ACTIVE = 6;
  localparam int unsigned MODE_STOP_IN_WAIT = 5;
  localparam int unsigned MODE_BUS_SYNC = 4;
  localparam int unsigned MODE_TIMER = 3;
  localparam int unsigned MODE_WAKE_EN = 2;
  localparam int unsigned MODE_SLEEP_REQ = 1;
  localparam int unsigned MODE_INIT_REQ = 0;
  localparam logic [7:0] MODE_RESET = 8'h01;

  // option_and_handshake_control fields
  localparam int unsigned OPT_MODULE_EN = 7;
  localparam int unsigned OPT_CLK_SRC = 6;
  localparam int unsigned OPT_LOOPBACK = 5;
  localparam int unsigned OPT_MONITOR = 4;
  localparam int unsigned OPT_BUSOFF_REC = 3;
  localparam int unsigned OPT_WAKE_FILTER = 2;
  localparam int unsigned OPT_SLEEP_ACK = 1;
  localparam int unsigned OPT_INIT_ACK = 0;
  localparam logic [7:0] OPTION_RESET = 8'h11;

  // receive flag / enable fields
  localparam int unsigned RXF_WAKE = 7;
  localparam int unsigned RXF_ERR_LO = 2;
  localparam int unsigned RXF_ERR_HI = 5;
  localparam int unsigned RXIE_WAKE = 7;
  localparam logic [7:0] RXFLAG_RESET = 8'h00;
  localparam logic [7:0] RXIEN_RESET = 8'h00;
  localparam logic [7:0] TIMING_RESET = 8'h00;

  // Resynchronisation counts
  localparam int unsigned SYNC_RECESSIVE_BITS = 11;
  localparam int unsigned BUSOFF_SEQUENCES = 128;

  // Wake filter: least dominant pulse, rounded up to whole cycles
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned WAKE_FILTER_NS = 2000;
  localparam int unsigned WAKE_FILTER_CYCLES =
    (WAKE_FILTER_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  typedef enum logic [1:0] {
    CANM_RUN,
    CANM_SLEEP,
    CANM_INIT,
    CANM_SYNC
  } canm_mode_t;

endpackage

//--- rtl/canm_run_counter.sv
`timescale 1ns/1ps
module canm_run_counter #(
  parameter int unsigned COUNT = 11,
  parameter int unsigned W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic event_in,
  input wire logic break_in,
  output logic done
);
  logic [W-1:0] count_reg;

  // Restarts after each completed run so runs can be chained
  always_ff @(posedge clk) begin
    if (rst || clear || break_in) begin
      count_reg <= '0;
    end else if (event_in) begin
      if (count_reg == W'(COUNT - 1)) begin
        count_reg <= '0;
      end else begin
        count_reg <= count_reg + W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst || clear || break_in) begin
      done <= 1'b0;
    end else begin
      done <= event_in && (count_reg == W'(COUNT - 1));
    end
  end
endmodule

//--- rtl/canm_wake_filter.sv
`timescale 1ns/1ps
module canm_wake_filter
  import canm_pkg::*;
#(
  parameter int unsigned FILTER_CYCLES = WAKE_FILTER_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic armed,
  input wire logic filter_on,
  canm_bus_if.sink bus,
  output logic wake
);
  logic [15:0] low_reg;

  // Counts consecutive dominant samples while sleeping
  always_ff @(posedge clk) begin
    if (rst || !armed || !bus.rx_dominant) begin
      low_reg <= '0;
    end else if (low_reg != 16'hFFFF) begin
      low_reg <= low_reg + 16'h0001;
    end
  end

  // Filtered mode rejects short glitches on the idle bus
  always_ff @(posedge clk) begin
    if (rst || !armed) begin
      wake <= 1'b0;
    end else if (filter_on) begin
      wake <= bus.rx_dominant && (low_reg >= 16'(FILTER_CYCLES - 1));
    end else begin
      wake <= bus.rx_dominant;
    end
  end
endmodule

//--- verification/canm_bus_node.sv
`timescale 1ns/1ps
module canm_bus_node #(
  parameter int unsigned TICK_DIV = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic tx_level,
  input wire logic drive_dominant,
  output logic rx_level,
  output logic bit_tick
);
  logic [7:0] div_reg;
  // Wired-AND bus: any dominant driver wins over recessive
  assign rx_level = tx_level & ~drive_dominant;
  assign bit_tick = !rst && div_reg == 8'(TICK_DIV - 1);
  always_ff @(posedge clk) begin
    if (rst || bit_tick) begin
      div_reg <= 8'h00;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end
endmodule

//--- verification/canm_mode_chk.sv
`timescale 1ns/1ps
module canm_mode_chk
  import canm_pkg::*;
(
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic PREADY,
  input wire logic CAN_RX,
  input wire logic BIT_TICK,
  input wire logic RX_ACTIVE,
  input wire logic TX_BUFFERS_EMPTY,
  input wire logic CPU_STOP,
  input wire logic CAN_TX,
  input wire logic INIT_MODE,
  input wire logic SLEEP_MODE,
  input wire logic BUS_SYNC,
  input wire logic [7:0] OPTION_CTRL,
  input wire logic [7:0] BIT_TIMING_0
);
  logic wr_init;
  logic [7:0] run_cnt;
  assign wr_init = PSEL && PENABLE && PREADY && PWRITE && PADDR == ADDR_MODE
    && PWDATA[MODE_INIT_REQ];
  // Recessive run seen since leaving init; saturates so long idle stays legal
  always_ff @(posedge MCLK) begin
    if (RESET || INIT_MODE || (BIT_TICK && !CAN_RX)) begin
      run_cnt <= 8'h00;
    end else if (BIT_TICK && run_cnt != 8'hFF) begin
      run_cnt <= run_cnt + 8'h01;
    end
  end
  default clocking @(posedge MCLK); endclocking
  default disable iff (RESET);
  // Mode flops follow one edge after the write, the option copy one edge later still
  a_init_entry_ack: assert property (wr_init |-> ##3 INIT_MODE && OPTION_CTRL[OPT_INIT_ACK])
    else $error("init entry not acknowledged");
  a_tx_init_recessive: assert property (wr_init |=> CAN_TX)
    else $error("transmit not recessive after init request");
  a_tx_stop_recessive: assert property (CPU_STOP |=> CAN_TX)
    else $error("transmit not recessive in stop");
  a_init_no_sync: assert property (wr_init |-> ##2 INIT_MODE && !BUS_SYNC)
    else $error("still synchronised in init");
  // Return from sleep goes straight to run and needs no recessive run
  a_sync_after_run: assert property ($rose(BUS_SYNC) && !$past(SLEEP_MODE) |->
    run_cnt >= 8'h0B)
    else $error("synchronised before eleven recessive bits");
  a_sleep_when_idle: assert property ($rose(SLEEP_MODE) |-> $past(!RX_ACTIVE && TX_BUFFERS_EMPTY))
    else $error("sleep entered while bus busy");
  a_timing_write_lock: assert property (!$stable(BIT_TIMING_0) |->
    $past(INIT_MODE && PSEL && PENABLE && PWRITE && PADDR == ADDR_TIMING0, 2))
    else $error("timing register changed outside init");
  a_ack_mirror_mode: assert property (OPTION_CTRL[OPT_INIT_ACK] == $past(INIT_MODE)
    && OPTION_CTRL[OPT_SLEEP_ACK] == $past(SLEEP_MODE))
    else $error("acknowledge differs from mode in force");
endmodule

bind canm_mode_control canm_mode_chk chk_u (
  .MCLK, .RESET, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PREADY, .CAN_RX, .BIT_TICK,
  .RX_ACTIVE, .TX_BUFFERS_EMPTY, .CPU_STOP, .CAN_TX, .INIT_MODE, .SLEEP_MODE, .BUS_SYNC,
  .OPTION_CTRL, .BIT_TIMING_0
);

//--- verification/test_can_mode_control.sv
`timescale 1ns/1ps
module test_can_mode_control
  import canm_pkg::*;
;
  logic MCLK, RESET, PSEL, PENABLE, PWRITE, TX_BIT, RX_ACTIVE, RX_FRAME_DONE;
  logic TX_BUFFERS_EMPTY, BUS_OFF, CPU_STOP, CPU_WAIT, dominant, CAN_RX, BIT_TICK;
  logic CAN_TX, INIT_MODE, SLEEP_MODE, BUS_SYNC, ABORT_XFER, TIMER_ENABLE, WAKE_PENDING;
  logic PREADY, PSLVERR, rerr;
  logic [7:0] PADDR, OPTION_CTRL, BIT_TIMING_0, BIT_TIMING_1;
  logic [31:0] PWDATA, PRDATA, rd;
  logic [3:0] ERR_STATE;
  int miscompares = 0;
  int comparisons = 0;
  int aborts = 0;

  canm_mode_control dut_u (.MCLK(MCLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .CAN_RX(CAN_RX), .BIT_TICK(BIT_TICK), .TX_BIT(TX_BIT),
    .RX_ACTIVE(RX_ACTIVE), .RX_FRAME_DONE(RX_FRAME_DONE), .TX_BUFFERS_EMPTY(TX_BUFFERS_EMPTY),
    .BUS_OFF(BUS_OFF), .ERR_STATE(ERR_STATE), .CPU_STOP(CPU_STOP), .CPU_WAIT(CPU_WAIT),
    .CAN_TX(CAN_TX), .INIT_MODE(INIT_MODE), .SLEEP_MODE(SLEEP_MODE), .BUS_SYNC(BUS_SYNC),
    .ABORT_XFER(ABORT_XFER), .TIMER_ENABLE(TIMER_ENABLE), .WAKE_PENDING(WAKE_PENDING),
    .OPTION_CTRL(OPTION_CTRL), .BIT_TIMING_0(BIT_TIMING_0), .BIT_TIMING_1(BIT_TIMING_1));
  canm_bus_node #(.TICK_DIV(4)) node_u (.clk(MCLK), .rst(RESET), .tx_level(CAN_TX),
    .drive_dominant(dominant), .rx_level(CAN_RX), .bit_tick(BIT_TICK));

  initial begin
    MCLK = 1'b0;
    forever #20 MCLK = ~MCLK;
  end

  always @(posedge MCLK) begin
    if (ABORT_XFER === 1'b1) begin
      aborts <= aborts + 1;
    end
  end

  task automatic close_out();
    $display("Counts: %0d comparisons, %0d miscompares", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] addr, input logic [7:0] data);
    int n;
    @(posedge MCLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= addr;
    PWDATA <= {24'h00_0000, data};
    @(posedge MCLK);
    PENABLE <= 1'b1;
    // Ready, data and response are all taken at the completing edge
    for (n = 0; n < 16; n++) begin
      @(posedge MCLK);
      if (PREADY === 1'b1) break;
    end
    rd = PRDATA;
    rerr = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    if (n == 16) begin
      miscompares++;
      $display("Error at %0t: no ready", $time);
      close_out();
    end
  endtask

  task automatic rchk(input logic [7:0] addr, input logic [7:0] exp);
    apb(1'b0, addr, 8'h00);
    check(rd, {24'h00_0000, exp});
  endtask

  // Bounded wait: sel 0 watches bus sync, 1 watches sleep
  task automatic wait_for(input int sel, input logic lvl, input int bound);
    int n;
    for (n = 0; n < bound; n++) begin
      @(negedge MCLK);
      if ((sel == 0 ? BUS_SYNC : SLEEP_MODE) === lvl) break;
    end
    if (n == bound) begin
      miscompares++;
      $display("Error at %0t: wait ran out", $time);
      close_out();
    end
  endtask

  task automatic look(input int n);
    repeat (n) @(negedge MCLK);
  endtask

  initial begin
    {RESET, TX_BIT, TX_BUFFERS_EMPTY} = 3'b111;
    {PSEL, PENABLE, PWRITE, RX_ACTIVE, RX_FRAME_DONE, BUS_OFF, CPU_STOP, CPU_WAIT} = 8'h00;
    dominant = 1'b0;
    PADDR = 8'h00;
    PWDATA = 32'h0000_0000;
    ERR_STATE = 4'hA;
    repeat (10) @(posedge MCLK);
    RESET <= 1'b0;
    look(1);
    check({CAN_TX, INIT_MODE}, 2'b11);
    rchk(ADDR_MODE, MODE_RESET);
    rchk(ADDR_OPTION, OPTION_RESET);
    apb(1'b1, 8'h40, 8'hFF);
    check(rerr, 1'b1);
    rchk(8'h40, 8'h00);
    rchk(ADDR_RXFLAG, 8'h28);
    apb(1'b1, ADDR_OPTION, 8'hFF);
    rchk(ADDR_OPTION, 8'hFD);
    apb(1'b1, ADDR_OPTION, 8'h80);
    apb(1'b1, ADDR_TIMING0, 8'hA5);
    rchk(ADDR_TIMING0, 8'hA5);
    check(BIT_TIMING_0, 8'hA5);
    apb(1'b1, ADDR_TIMING1, 8'h3C);
    rchk(ADDR_TIMING1, 8'h3C);
    check(BIT_TIMING_1, 8'h3C);
    apb(1'b1, ADDR_MODE, 8'h00);
    wait_for(0, 1'b1, 200);
    rchk(ADDR_OPTION, 8'h80);
    apb(1'b1, ADDR_TIMING0, 8'h5A);
    apb(1'b1, ADDR_OPTION, 8'h00);
    rchk(ADDR_TIMING0, 8'hA5);
    rchk(ADDR_OPTION, 8'h80);
    @(posedge MCLK);
    TX_BIT <= 1'b0;
    look(3);
    check(CAN_TX, 1'b0);
    @(posedge MCLK);
    CPU_STOP <= 1'b1;
    look(2);
    check(CAN_TX, 1'b1);
    @(posedge MCLK);
    CPU_STOP <= 1'b0;
    apb(1'b1, ADDR_MODE, 8'h20);
    look(2);
    check(CAN_TX, 1'b0);
    @(posedge MCLK);
    CPU_WAIT <= 1'b1;
    look(2);
    check(CAN_TX, 1'b1);
    @(posedge MCLK);
    CPU_WAIT <= 1'b0;
    TX_BIT <= 1'b1;
    // Wake interrupt and wake enable set up before sleeping
    apb(1'b1, ADDR_RXIEN, 8'h80);
    apb(1'b1, ADDR_MODE, 8'h04);
    @(posedge MCLK);
    RX_ACTIVE <= 1'b1;
    apb(1'b1, ADDR_MODE, 8'h06);
    look(4);
    check(SLEEP_MODE, 1'b0);
    apb(1'b1, ADDR_MODE, 8'h04);
    rchk(ADDR_MODE, 8'h56);
    @(posedge MCLK);
    RX_ACTIVE <= 1'b0;
    wait_for(1, 1'b1, 20);
    rchk(ADDR_OPTION, 8'h82);
    @(posedge MCLK);
    dominant <= 1'b1;
    wait_for(1, 1'b0, 20);
    @(posedge MCLK);
    dominant <= 1'b0;
    rchk(ADDR_RXFLAG, 8'hA8);
    check(WAKE_PENDING, 1'b1);
    apb(1'b1, ADDR_MODE, 8'h06);
    apb(1'b0, ADDR_MODE, 8'h00);
    check(rd[2:0], 3'h4);
    apb(1'b1, ADDR_RXFLAG, 8'h80);
    rchk(ADDR_RXFLAG, 8'h28);
    check(WAKE_PENDING, 1'b0);
    apb(1'b1, ADDR_MODE, 8'h02);
    wait_for(1, 1'b1, 20);
    @(posedge MCLK);
    dominant <= 1'b1;
    look(8);
    check(SLEEP_MODE, 1'b1);
    @(posedge MCLK);
    dominant <= 1'b0;
    apb(1'b1, ADDR_MODE, 8'h00);
    wait_for(1, 1'b0, 20);
    rchk(ADDR_OPTION, 8'h80);
    apb(1'b1, ADDR_MODE, 8'h08);
    apb(1'b1, ADDR_RXIEN, 8'h80);
    check(TIMER_ENABLE, 1'b1);
    @(posedge MCLK);
    RX_FRAME_DONE <= 1'b1;
    @(posedge MCLK);
    RX_FRAME_DONE <= 1'b0;
    apb(1'b0, ADDR_MODE, 8'h00);
    check(rd[7], 1'b1);
    @(posedge MCLK);
    TX_BIT <= 1'b0;
    look(2);
    check(CAN_TX, 1'b0);
    apb(1'b1, ADDR_MODE, 8'h01);
    look(1);
    check(CAN_TX, 1'b1);
    look(2);
    check({INIT_MODE, BUS_SYNC, TIMER_ENABLE}, 3'b100);
    check(aborts, 1);
    rchk(ADDR_MODE, 8'h01);
    rchk(ADDR_RXIEN, 8'h00);
    rchk(ADDR_RXFLAG, 8'h28);
    @(posedge MCLK);
    BUS_OFF <= 1'b1;
    TX_BIT <= 1'b1;
    apb(1'b1, ADDR_MODE, 8'h00);
    look(200);
    check(BUS_SYNC, 1'b0);
    wait_for(0, 1'b1, 7000);
    // Init requested from sleep, the gentle way in
    @(posedge MCLK);
    BUS_OFF <= 1'b0;
    apb(1'b1, ADDR_MODE, 8'h02);
    wait_for(1, 1'b1, 20);
    apb(1'b1, ADDR_MODE, 8'h03);
    look(3);
    check(OPTION_CTRL, 8'h81);
    rchk(ADDR_MODE, 8'h03);
    close_out();
  end
endmodule
